// ### meter_event_pkg.sv
/*
  Package for the upper event status block: register offsets, bit positions,
  reset values and sizes.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package meter_event_pkg;
  localparam int unsigned  DATA_W          = 32;
  localparam int unsigned  ADDR_W          = 12;
  localparam logic [11:0]  OFF_STATUS      = 12'h000;
  localparam logic [11:0]  OFF_MASK        = 12'h004;
  localparam logic [11:0]  OFF_THRESH      = 12'h008;
  localparam logic [11:0]  OFF_PHASE       = 12'h00C;
  localparam logic [11:0]  OFF_CONFIG      = 12'h010;
  localparam logic [11:0]  OFF_CUR_PEAK    = 12'h014;
  localparam logic [11:0]  OFF_VOLT_PEAK   = 12'h018;
  localparam logic [11:0]  OFF_CHECKSUM    = 12'h01C;
  localparam int unsigned  BIT_ZX_VC       = 11;
  localparam int unsigned  BIT_ZX_IA       = 12;
  localparam int unsigned  BIT_ZX_IB       = 13;
  localparam int unsigned  BIT_ZX_IC       = 14;
  localparam int unsigned  BIT_RST_DONE    = 15;
  localparam int unsigned  BIT_SAG         = 16;
  localparam int unsigned  BIT_OI          = 17;
  localparam int unsigned  BIT_OV          = 18;
  localparam int unsigned  BIT_ORDER       = 19;
  localparam int unsigned  BIT_MISMATCH    = 20;
  localparam int unsigned  BIT_PK_CUR      = 23;
  localparam int unsigned  BIT_PK_VOLT     = 24;
  localparam int unsigned  BIT_CRC         = 25;
  localparam int unsigned  BIT_SOFT_RST    = 7;
  localparam int unsigned  PH_OI_LSB       = 3;
  localparam int unsigned  PH_OV_LSB       = 9;
  localparam int unsigned  PH_SAG_LSB      = 12;
  localparam logic [31:0]  STATUS_FLAGS    = 32'h03DFF800;
  localparam logic [31:0]  STATUS_ONE      = 32'h00200000;
  localparam logic [31:0]  STATUS_RESET    = 32'h00208000;
  localparam logic [31:0]  MASK_RESET      = 32'h00000000;
  localparam logic [31:0]  PHASE_FIELDS    = 32'h00007E38;
  localparam logic [31:0]  CONFIG_KEEP     = 32'hFFFFFF7F;
  localparam int unsigned  SAMPLE_W        = 24;
  localparam int unsigned  PEAK_W          = 27;
  localparam int unsigned  PHASE_SEL_W     = 3;
  localparam int unsigned  CHECKSUM_W      = 32;
endpackage

// ### meter_event_status_upper.sv
/*
  Upper event status word of a polyphase meter with sticky flags, masks,
  reset-complete signalling and an APB slave.
  Assumes detection pulses come from logic on pclk; the power mode and the
  event pulses are synchronous, and the primary interrupt pin is active low.
*/
// Summary of operation
// RULE1: Voltage C crossing sets bit 11, current A/B/C crossings set 12-14.
// RULE2: Reset-complete bit 15 is set only once all registers hold defaults.
// RULE3: Soft reset command, hardware reset or return to normal mode set it.
// RULE4: While bit 15 is set the primary interrupt pin is low, with no mask.
// RULE5: A sag sets bit 16 and phases are kept in phase status bits 14:12.
// RULE6: Overcurrent sets bit 17 and phases are kept in bits 5:3.
// RULE7: Overvoltage sets bit 18 and phases are kept in bits 11:9.
// RULE8: Rising A then rising C before B sets bit 19.
// RULE9: Bit 20 sets when |summed current - neutral| exceeds the threshold.
// RULE10: Bit 21 reads as one and resets to one.
// RULE11: Bit 22 reads as zero.
// RULE12: End of current peak period sets bit 23 and loads the peak register.
// RULE13: End of voltage peak period sets bit 24 and loads the peak register.
// RULE14: A change of the checksum register value sets bit 25.
// RULE15: Bits 31:26 read as zero.
// RULE16: Flags stay set until a one is written there; zero leaves them.
`timescale 1ns/1ps
module meter_event_status_upper (
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [meter_event_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [meter_event_pkg::DATA_W-1:0]     pwdata,
  output logic      [meter_event_pkg::DATA_W-1:0]     prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic                                   volt_c_crossing,
  input  wire logic [2:0]                             curr_crossing,
  input  wire logic                                   volt_a_rising,
  input  wire logic                                   volt_b_rising,
  input  wire logic                                   volt_c_rising,
  input  wire logic [2:0]                             sag_phase,
  input  wire logic [2:0]                             overcurrent_phase,
  input  wire logic [2:0]                             overvoltage_phase,
  input  wire logic                                   sample_valid,
  input  wire logic signed [meter_event_pkg::SAMPLE_W-1:0]
                                                      summed_phase_current,
  input  wire logic signed [meter_event_pkg::SAMPLE_W-1:0]
                                                      neutral_current_sample,
  input  wire logic                                   cur_peak_end,
  input  wire logic                                   volt_peak_end,
  input  wire logic [meter_event_pkg::PEAK_W-1:0]     peak_value,
  input  wire logic [meter_event_pkg::PHASE_SEL_W-1:0] peak_phase,
  input  wire logic [meter_event_pkg::CHECKSUM_W-1:0] checksum_value,
  input  wire logic                                   normal_power_mode,
  output logic                                        primary_interrupt_pin_n,
  output logic                                        event_irq,
  output logic                                        soft_reset_pulse
);
  import meter_event_pkg::*;

  typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_SOFT} init_state_t;

  // Status, mask and software-visible registers
  logic [DATA_W-1:0]   status_q, status_d;
  logic [DATA_W-1:0]   mask_q;
  logic [SAMPLE_W:0]   thresh_q;
  logic [DATA_W-1:0]   phase_q;
  logic [DATA_W-1:0]   config_q;
  logic [DATA_W-1:0]   cur_peak_q;
  logic [DATA_W-1:0]   volt_peak_q;
  logic [CHECKSUM_W-1:0] checksum_q;
  logic                order_armed_q;
  logic                mode_prev_q;
  init_state_t         init_q, init_d;

  function automatic logic [SAMPLE_W:0] abs_diff(
    input logic signed [SAMPLE_W-1:0] a,
    input logic signed [SAMPLE_W-1:0] b
  );
    logic signed [SAMPLE_W:0] d;
    d = {a[SAMPLE_W-1], a} - {b[SAMPLE_W-1], b};
    abs_diff = d[SAMPLE_W] ? -d : d;
  endfunction

  function automatic logic [DATA_W-1:0] peak_word(
    input logic [PEAK_W-1:0]      v,
    input logic [PHASE_SEL_W-1:0] p
  );
    peak_word = {2'h0, p, v};
  endfunction

  // Bus decode
  wire access_w   = psel & penable;
  wire wr_w       = access_w & pwrite;
  wire sel_status = paddr == OFF_STATUS;
  wire sel_mask   = paddr == OFF_MASK;
  wire sel_thresh = paddr == OFF_THRESH;
  wire sel_phase  = paddr == OFF_PHASE;
  wire sel_config = paddr == OFF_CONFIG;
  wire sel_cpeak  = paddr == OFF_CUR_PEAK;
  wire sel_voltage_peak_register  = paddr == OFF_VOLT_PEAK;
  wire sel_csum   = paddr == OFF_CHECKSUM;
  wire mapped_w   = sel_status | sel_mask | sel_thresh | sel_phase |
                    sel_config | sel_cpeak | sel_voltage_peak_register | sel_csum;
  wire [DATA_W-1:0] clear_w = (wr_w & sel_status) ? pwdata : '0;
  wire soft_cmd_w = wr_w & sel_config & pwdata[BIT_SOFT_RST];

  // Event detection
  wire order_err_w = order_armed_q & volt_c_rising & ~volt_b_rising; // [RULE8]
  wire mismatch_w  = sample_valid &
    (abs_diff(summed_phase_current, neutral_current_sample) >
     thresh_q); // [RULE9]
  wire csum_chg_w  = (checksum_value != checksum_q) &
                     (init_q == ST_RUN); // [RULE14]
  wire wake_w      = normal_power_mode & ~mode_prev_q; // [RULE3]
  wire done_w      = (init_q != ST_RUN); // [RULE2]

  logic [DATA_W-1:0] set_w;
  always_comb begin
    set_w               = '0;
    set_w[BIT_ZX_VC]    = volt_c_crossing; // [RULE1]
    set_w[BIT_ZX_IA]    = curr_crossing[0]; // [RULE1]
    set_w[BIT_ZX_IB]    = curr_crossing[1]; // [RULE1]
    set_w[BIT_ZX_IC]    = curr_crossing[2]; // [RULE1]
    set_w[BIT_RST_DONE] = done_w; // [RULE2]
    set_w[BIT_SAG]      = |sag_phase; // [RULE5]
    set_w[BIT_OI]       = |overcurrent_phase; // [RULE6]
    set_w[BIT_OV]       = |overvoltage_phase; // [RULE7]
    set_w[BIT_ORDER]    = order_err_w; // [RULE8]
    set_w[BIT_MISMATCH] = mismatch_w; // [RULE9]
    set_w[BIT_PK_CUR]   = cur_peak_end; // [RULE12]
    set_w[BIT_PK_VOLT]  = volt_peak_end; // [RULE13]
    set_w[BIT_CRC]      = csum_chg_w; // [RULE14]
  end

  // Set wins over clear; fixed bits forced
  always_comb begin
    status_d = ((status_q & ~clear_w) | set_w) & STATUS_FLAGS; // [RULE16]
    status_d = status_d | STATUS_ONE; // [RULE10] [RULE11] [RULE15]
  end

  // Default load sequence: one cycle at defaults, then flag is raised
  always_comb begin
    case (init_q)
      ST_INIT: init_d = ST_RUN;
      ST_SOFT: init_d = ST_RUN;
      ST_RUN:  init_d = (soft_cmd_w | wake_w) ? ST_SOFT : ST_RUN; // [RULE3]
      default: init_d = ST_RUN;
    endcase
  end

  wire reload_w = (init_q == ST_RUN) & (soft_cmd_w | wake_w);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= ST_INIT;
    end else begin
      init_q <= init_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= STATUS_RESET & ~(32'h1 << BIT_RST_DONE); // [RULE2]
    end else if (reload_w) begin
      status_q <= STATUS_ONE; // [RULE2]
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q        <= MASK_RESET;
      thresh_q      <= '0;
      config_q      <= '0;
      order_armed_q <= 1'b0;
      mode_prev_q   <= 1'b1;
    end else if (reload_w) begin
      mask_q        <= MASK_RESET;
      thresh_q      <= '0;
      config_q      <= '0;
      order_armed_q <= 1'b0;
      mode_prev_q   <= normal_power_mode;
    end else begin
      mode_prev_q <= normal_power_mode;
      if (wr_w & sel_mask) begin
        mask_q <= pwdata & STATUS_FLAGS & ~(32'h1 << BIT_RST_DONE);
      end
      if (wr_w & sel_thresh) begin
        thresh_q <= pwdata[SAMPLE_W:0];
      end
      if (wr_w & sel_config) begin
        config_q <= pwdata & CONFIG_KEEP;
      end
      if (volt_a_rising) begin
        order_armed_q <= 1'b1; // [RULE8]
      end else if (volt_b_rising | volt_c_rising) begin
        order_armed_q <= 1'b0; // [RULE8]
      end
    end
  end

  // Phase status, peaks and checksum shadow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q     <= '0;
      cur_peak_q  <= '0;
      volt_peak_q <= '0;
      checksum_q  <= '0;
    end else if (reload_w | (init_q != ST_RUN)) begin
      phase_q     <= '0;
      cur_peak_q  <= '0;
      volt_peak_q <= '0;
      checksum_q  <= checksum_value;
    end else begin
      checksum_q <= checksum_value;
      phase_q <= phase_q |
        ({29'h0, sag_phase} << PH_SAG_LSB) | // [RULE5]
        ({29'h0, overcurrent_phase} << PH_OI_LSB) | // [RULE6]
        ({29'h0, overvoltage_phase} << PH_OV_LSB); // [RULE7]
      if (wr_w & sel_phase) begin
        phase_q <= (phase_q & ~(pwdata & PHASE_FIELDS)) |
          ({29'h0, sag_phase} << PH_SAG_LSB) |
          ({29'h0, overcurrent_phase} << PH_OI_LSB) |
          ({29'h0, overvoltage_phase} << PH_OV_LSB);
      end
      if (cur_peak_end) begin
        cur_peak_q <= peak_word(peak_value, peak_phase); // [RULE12]
      end
      if (volt_peak_end) begin
        volt_peak_q <= peak_word(peak_value, peak_phase); // [RULE13]
      end
    end
  end

  // Read data
  wire [DATA_W-1:0] rd_mux =
    sel_status ? status_q :
    sel_mask   ? mask_q :
    sel_thresh ? {{(DATA_W-SAMPLE_W-1){1'b0}}, thresh_q} :
    sel_phase  ? phase_q :
    sel_config ? config_q :
    sel_cpeak  ? cur_peak_q :
    sel_voltage_peak_register  ? volt_peak_q :
    sel_csum   ? checksum_q : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access_w & ~mapped_w;
  assign soft_reset_pulse = reload_w & soft_cmd_w;
  assign event_irq = |(status_q & mask_q);
  assign primary_interrupt_pin_n =
    ~(event_irq | status_q[BIT_RST_DONE]); // [RULE4]
endmodule

// ### meter_event_status_upper_properties.sv
/* Checker for the upper event status block.
   Sees only the top module ports; bound below. */
`timescale 1ns/1ps
module meter_event_status_upper_properties
  import meter_event_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        primary_interrupt_pin_n,
  input wire logic        event_irq,
  input wire logic        soft_reset_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_status_read;
    psel && penable && !pwrite && paddr == OFF_STATUS;
  endsequence
  sequence s_soft_write;
    psel && penable && pwrite && paddr == OFF_CONFIG && pwdata[BIT_SOFT_RST];
  endsequence
  a_ready_always: assert property (psel && penable |-> pready)
    else $error("ready low");
  a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > OFF_CHECKSUM)) else $error("bad slave error");
  a_fixed_bits: assert property (s_status_read |->
    prdata[31:26] == 6'h00 && !prdata[22] && prdata[21])
    else $error("fixed status bits wrong");
  a_irq_pin: assert property (event_irq |-> !primary_interrupt_pin_n)
    else $error("pin high with interrupt");
  a_reset_pin: assert property ($rose(presetn) |=> !primary_interrupt_pin_n)
    else $error("pin not low after reset");
  a_soft_pin: assert property (s_soft_write |->
    ##1 primary_interrupt_pin_n ##1 !primary_interrupt_pin_n)
    else $error("soft reset pin sequence wrong");
  a_soft_pulse: assert property (s_soft_write |-> ##[0:1] soft_reset_pulse)
    else $error("no soft reset pulse");
  a_pulse_once: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
endmodule
bind meter_event_status_upper meter_event_status_upper_properties u_props (.*);

// ### meter_event_status_upper_tb.sv
/* Self-checking bench for the upper event status block.
   Bench drives every input; APB master and event pulses on pclk. */
`timescale 1ns/1ps
module meter_event_status_upper_tb;
  import meter_event_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sample_valid, last_err;
  logic normal_power_mode, pready, pslverr, event_irq;
  logic primary_interrupt_pin_n, soft_reset_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, checksum_value, rd_data;
  logic [17:0] ev;
  logic [26:0] peak_value;
  logic [2:0] peak_phase;
  logic signed [23:0] sum_i, neu_i;
  int n_errors, n_checks, thr, nu, dd;
  meter_event_status_upper u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .volt_c_crossing(ev[0]), .curr_crossing(ev[3:1]),
    .sag_phase(ev[6:4]), .overcurrent_phase(ev[9:7]),
    .overvoltage_phase(ev[12:10]), .cur_peak_end(ev[13]),
    .volt_peak_end(ev[14]), .volt_a_rising(ev[15]),
    .volt_b_rising(ev[16]), .volt_c_rising(ev[17]),
    .sample_valid(sample_valid), .summed_phase_current(sum_i),
    .neutral_current_sample(neu_i), .peak_value(peak_value),
    .peak_phase(peak_phase), .checksum_value(checksum_value),
    .normal_power_mode(normal_power_mode), .event_irq(event_irq),
    .primary_interrupt_pin_n(primary_interrupt_pin_n),
    .soft_reset_pulse(soft_reset_pulse));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_data, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge pclk);
    ev <= 18'h1 << i;
    @(posedge pclk);
    ev <= 18'h0;
  endtask
  task automatic clr();
    apb(1'b1, OFF_STATUS, 32'hFFFFFFFF);
    apb(1'b1, OFF_PHASE, PHASE_FIELDS);
  endtask
  function automatic logic [31:0] flag_of(input int i);
    int b;
    b = i < 4 ? 11 + i : i < 7 ? 16 : i < 10 ? 17 : i < 13 ? 18 : i + 10;
    return STATUS_ONE | (32'h1 << b);
  endfunction
  function automatic logic [31:0] phase_of(input int i);
    if (i < 4 || i > 12) return 32'h0;
    return 32'h1 << (i < 7 ? i + 8 : i < 10 ? i - 4 : i - 1);
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_sim();
  end
  initial begin
    rd_data = $urandom(32'hC668);
    {psel, penable, pwrite, sample_valid, presetn, ev} = '0;
    {paddr, pwdata, sum_i, neu_i, peak_value, peak_phase} = '0;
    normal_power_mode = 1'b1;
    checksum_value = $urandom;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFF_STATUS, STATUS_RESET);
    chk(primary_interrupt_pin_n, 32'h0);
    clr();
    chk(primary_interrupt_pin_n, 32'h1);
    apb(1'b1, OFF_MASK, STATUS_FLAGS);
    for (int i = 0; i < 15; i++) begin
      clr();
      peak_value <= 27'($urandom);
      peak_phase <= 3'($urandom);
      pulse(i);
      apb(1'b1, OFF_STATUS, ~flag_of(i));
      rdc(OFF_STATUS, flag_of(i));
      chk(event_irq, 32'h1);
      if (phase_of(i) != 0) rdc(OFF_PHASE, phase_of(i));
      if (i > 12) rdc(i == 13 ? OFF_CUR_PEAK : OFF_VOLT_PEAK,
                      {2'b00, peak_phase, peak_value});
    end
    clr();
    checksum_value <= checksum_value + 32'($urandom_range(1, 255));
    rdc(OFF_STATUS, STATUS_ONE | 32'h02000000);
    for (int k = 0; k < 2; k++) begin
      clr();
      pulse(15);
      if (k == 1) pulse(16);
      pulse(17);
      rdc(OFF_STATUS, STATUS_ONE | (k == 0 ? 32'h00080000 : 32'h0));
    end
    thr = int'($urandom_range(1000, 1000000));
    apb(1'b1, OFF_THRESH, 32'(thr));
    for (int k = 0; k < 3; k++) begin
      clr();
      nu = int'($urandom_range(0, 2000)) - 1000;
      dd = k == 0 ? thr + 1 : k == 1 ? -thr - 1 : thr;
      neu_i <= 24'(nu);
      sum_i <= 24'(nu + dd);
      sample_valid <= 1'b1;
      @(posedge pclk);
      sample_valid <= 1'b0;
      rdc(OFF_STATUS, STATUS_ONE | (k < 2 ? 32'h00100000 : 32'h0));
    end
    rdc(12'h020, 32'h0);
    chk(last_err, 32'h1);
    pulse(0);
    apb(1'b1, OFF_CONFIG, 32'h1 << BIT_SOFT_RST);
    repeat (3) @(posedge pclk);
    rdc(OFF_STATUS, STATUS_RESET);
    rdc(OFF_MASK, MASK_RESET);
    chk(primary_interrupt_pin_n, 32'h0);
    clr();
    normal_power_mode <= 1'b0;
    repeat (4) @(posedge pclk);
    normal_power_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc(OFF_STATUS, STATUS_RESET);
    clr();
    pulse(4);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFF_STATUS, STATUS_RESET);
    end_sim();
  end
endmodule
